/* File: src/prs_params.svh */
// constants for the processor register stack
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_GR_COUNT      16
`define PRS_GR_WIDTH      32
`define PRS_FP_COUNT      4
`define PRS_FP_WIDTH      64
`define PRS_WK_COUNT      8
`define PRS_WK_WIDTH      32
`define PRS_HALF_WIDTH    16
`define PRS_SIGN_BIT      31
`define PRS_NIB_WIDTH     4
`define PRS_IND_MAX_LEVEL 8
`endif

/* File: src/prs_pkg.sv */
// types shared by the processor register stack
package prs_pkg;
    typedef enum logic [2:0] {
        PRS_OP_NONE   = 3'b000,
        PRS_OP_GR_W   = 3'b001,
        PRS_OP_GR_H   = 3'b010,
        PRS_OP_GR_D   = 3'b011,
        PRS_OP_FP_S   = 3'b100,
        PRS_OP_FP_L   = 3'b101,
        PRS_OP_WK     = 3'b110,
        PRS_OP_WK_CNV = 3'b111
    } prs_op_e;

    typedef enum logic [1:0] {
        PRS_CNV_NONE   = 2'b00,
        PRS_CNV_PACK   = 2'b01,
        PRS_CNV_UNPACK = 2'b10
    } prs_cnv_e;

    typedef enum logic [1:0] {
        PRS_IND_IDLE = 2'b00,
        PRS_IND_WALK = 2'b01,
        PRS_IND_DONE = 2'b10,
        PRS_IND_ERR  = 2'b11
    } prs_ind_e;

    typedef struct packed {
        logic          en;
        prs_op_e       op;
        logic [3:0]    sel;
        logic [63:0]   data;
        prs_cnv_e      cnv;
    } prs_wr_s;

    typedef struct packed {
        prs_op_e       op;
        logic [3:0]    sel;
    } prs_rd_s;
endpackage

/* File: src/prs_stack.sv */
// register stack: general, floating point and decimal working registers
//Behaviour
//- two banks of sixteen general registers for arithmetic, logic, indexing
//- fixed point values are twos complement, top bit one means negative
//- one general register is read and written as one 32-bit operand
//- half word loads sign-extend into the full 32-bit register
//- double word is 64 bits in an even/odd pair, even holds the upper half
//- four floating point registers of 64 bits, short or long operands
//- short floating operands use upper half, lower half left unchanged
//- 4-bit fields select registers, operation decides floating or general
//- floating point registers answer only to numbers 0, 2, 4, 6
//- eight working registers hold packed or unpacked decimal fields
//- decimal arithmetic operands are always packed
//- packed: two digits per byte, sign in low nibble of low byte
//- unpacked: digit in low nibble, zone above, low zone holds the sign
//- working registers convert between packed and unpacked both ways
//- floating and decimal values are sign plus magnitude
//- address is base plus one or two index registers, relocated, indirect
//- indirect chains run at most eight levels deep
`timescale 1ns/1ns
`include "prs_params.svh"
module prs_stack #(
    parameter int GR_COUNT = `PRS_GR_COUNT,
    parameter int FP_COUNT = `PRS_FP_COUNT,
    parameter int WK_COUNT = `PRS_WK_COUNT,
    parameter int IND_MAX  = `PRS_IND_MAX_LEVEL
) (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic               bank_sel,
    input  wire prs_pkg::prs_wr_s   wr,
    input  wire prs_pkg::prs_rd_s   rd,
    output logic [63:0]             rd_data,
    output logic                    rd_neg,
    output logic                    rd_bad_sel,
    input  wire logic [3:0]         idx1_sel,
    input  wire logic               idx1_en,
    input  wire logic [3:0]         idx2_sel,
    input  wire logic               idx2_en,
    input  wire logic [23:0]        disp,
    input  wire logic [23:0]        reloc,
    output logic [23:0]             eff_addr,
    input  wire logic               ind_start,
    input  wire logic               ind_more,
    output logic                    ind_busy,
    output logic                    ind_overrun
);
    // contents carry no reset value
    logic [31:0] gr [2][GR_COUNT];
    logic [63:0] fp [FP_COUNT];
    logic [31:0] wk [WK_COUNT];

    logic [3:0]  pair_hi;
    logic [1:0]  fp_idx;
    logic        fp_ok;
    logic [2:0]  wk_idx;
    logic [31:0] half_ext;
    logic [31:0] cnv_val;

    assign pair_hi  = {wr.sel[3:1], 1'b1};
    assign fp_idx   = wr.sel[2:1];
    assign fp_ok    = (wr.sel[3] == 1'b0) && (wr.sel[0] == 1'b0);
    assign wk_idx   = wr.sel[2:0];
    assign half_ext = {{(`PRS_GR_WIDTH-`PRS_HALF_WIDTH){wr.data[`PRS_HALF_WIDTH-1]}},
                       wr.data[`PRS_HALF_WIDTH-1:0]};

    // pack: four zoned digits to packed nibbles, sign zone to low nibble
    function automatic logic [31:0] prs_pack(input logic [31:0] z);
        logic [31:0] p;
        p = '0;
        p[3:0]   = z[7:4];
        p[7:4]   = z[3:0];
        p[11:8]  = z[11:8];
        p[15:12] = z[19:16];
        p[19:16] = z[27:24];
        return p;
    endfunction

    // unpack: packed digits to zoned bytes, sign to low zone, other zones zero
    function automatic logic [31:0] prs_unpack(input logic [31:0] p);
        logic [31:0] z;
        z = '0;
        z[3:0]   = p[7:4];
        z[7:4]   = p[3:0];
        z[11:8]  = p[11:8];
        z[19:16] = p[15:12];
        z[27:24] = p[19:16];
        return z;
    endfunction

    always_comb begin
        cnv_val = wk[wk_idx];
        case (wr.cnv)
            prs_pkg::PRS_CNV_PACK:   cnv_val = prs_pack(wk[wk_idx]);
            prs_pkg::PRS_CNV_UNPACK: cnv_val = prs_unpack(wk[wk_idx]);
            default:                 cnv_val = wk[wk_idx];
        endcase
    end

    always_ff @(posedge mclk) begin
        if (wr.en) begin
            case (wr.op)
                prs_pkg::PRS_OP_GR_W: gr[bank_sel][wr.sel] <= wr.data[31:0];
                prs_pkg::PRS_OP_GR_H: gr[bank_sel][wr.sel] <= half_ext;
                prs_pkg::PRS_OP_GR_D: begin
                    gr[bank_sel][{wr.sel[3:1], 1'b0}] <= wr.data[63:32];
                    gr[bank_sel][pair_hi]             <= wr.data[31:0];
                end
                prs_pkg::PRS_OP_FP_S: if (fp_ok) begin
                    fp[fp_idx][63:32] <= wr.data[63:32];
                end
                prs_pkg::PRS_OP_FP_L: if (fp_ok) begin
                    fp[fp_idx] <= wr.data;
                end
                prs_pkg::PRS_OP_WK:     wk[wk_idx] <= wr.data[31:0];
                prs_pkg::PRS_OP_WK_CNV: wk[wk_idx] <= cnv_val;
                default: ;
            endcase
        end
    end

    logic [63:0] next_rd_data;
    logic        next_rd_bad;
    logic        rd_fp_ok;
    assign rd_fp_ok = (rd.sel[3] == 1'b0) && (rd.sel[0] == 1'b0);

    always_comb begin
        next_rd_data = '0;
        next_rd_bad  = 1'b0;
        case (rd.op)
            prs_pkg::PRS_OP_GR_W,
            prs_pkg::PRS_OP_GR_H: next_rd_data = {32'h0000_0000, gr[bank_sel][rd.sel]};
            prs_pkg::PRS_OP_GR_D: next_rd_data = {gr[bank_sel][{rd.sel[3:1], 1'b0}],
                                                  gr[bank_sel][{rd.sel[3:1], 1'b1}]};
            prs_pkg::PRS_OP_FP_S: begin
                next_rd_data = rd_fp_ok ? {fp[rd.sel[2:1]][63:32], 32'h0000_0000} : '0;
                next_rd_bad  = !rd_fp_ok;
            end
            prs_pkg::PRS_OP_FP_L: begin
                next_rd_data = rd_fp_ok ? fp[rd.sel[2:1]] : '0;
                next_rd_bad  = !rd_fp_ok;
            end
            prs_pkg::PRS_OP_WK,
            prs_pkg::PRS_OP_WK_CNV: next_rd_data = {32'h0000_0000, wk[rd.sel[2:0]]};
            default: next_rd_data = '0;
        endcase
    end

    // sign: twos complement top bit for binary, sign field for others
    logic next_rd_neg;
    always_comb begin
        case (rd.op)
            prs_pkg::PRS_OP_GR_W,
            prs_pkg::PRS_OP_GR_H: next_rd_neg = next_rd_data[`PRS_SIGN_BIT];
            prs_pkg::PRS_OP_GR_D: next_rd_neg = next_rd_data[63];
            prs_pkg::PRS_OP_FP_S,
            prs_pkg::PRS_OP_FP_L: next_rd_neg = next_rd_data[63];
            prs_pkg::PRS_OP_WK,
            prs_pkg::PRS_OP_WK_CNV: next_rd_neg = (next_rd_data[3:0] == 4'hd) ||
                                                  (next_rd_data[3:0] == 4'hb);
            default: next_rd_neg = 1'b0;
        endcase
    end

    // operand address: displacement plus optional indexes, then relocation
    logic [23:0] next_eff_addr;
    logic [23:0] ix1;
    logic [23:0] ix2;
    // register zero named as an index means no index
    assign ix1 = (idx1_en && idx1_sel != 4'h0) ? gr[bank_sel][idx1_sel][23:0] : 24'h00_0000;
    assign ix2 = (idx2_en && idx2_sel != 4'h0) ? gr[bank_sel][idx2_sel][23:0] : 24'h00_0000;
    assign next_eff_addr = disp + ix1 + ix2 + reloc;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data    <= '0;
            rd_neg     <= 1'b0;
            rd_bad_sel <= 1'b0;
            eff_addr   <= '0;
        end else begin
            rd_data    <= next_rd_data;
            rd_neg     <= next_rd_neg;
            rd_bad_sel <= next_rd_bad;
            eff_addr   <= next_eff_addr;
        end
    end

    // indirect chain depth limiter
    prs_pkg::prs_ind_e ind_state;
    prs_pkg::prs_ind_e next_ind_state;
    logic [3:0] ind_lvl;
    logic [3:0] next_ind_lvl;

    always_comb begin
        next_ind_state = ind_state;
        next_ind_lvl   = ind_lvl;
        case (ind_state)
            prs_pkg::PRS_IND_IDLE: if (ind_start) begin
                next_ind_state = prs_pkg::PRS_IND_WALK;
                next_ind_lvl   = 4'h1;
            end
            prs_pkg::PRS_IND_WALK: begin
                if (!ind_more) begin
                    next_ind_state = prs_pkg::PRS_IND_DONE;
                end else if (ind_lvl == 4'(IND_MAX)) begin
                    next_ind_state = prs_pkg::PRS_IND_ERR;
                end else begin
                    next_ind_lvl = ind_lvl + 4'h1;
                end
            end
            prs_pkg::PRS_IND_DONE,
            prs_pkg::PRS_IND_ERR: next_ind_state = prs_pkg::PRS_IND_IDLE;
            default: next_ind_state = prs_pkg::PRS_IND_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ind_state <= prs_pkg::PRS_IND_IDLE;
            ind_lvl   <= 4'h0;
        end else begin
            ind_state <= next_ind_state;
            ind_lvl   <= next_ind_lvl;
        end
    end

    assign ind_busy    = (ind_state == prs_pkg::PRS_IND_WALK);
    assign ind_overrun = (ind_state == prs_pkg::PRS_IND_ERR);

    sequence s_walk_full;
        ind_busy && ind_more && ind_lvl == 4'(IND_MAX);
    endsequence

    AST_IND_LIMIT: assert property (@(posedge mclk) disable iff (!rst_b)
        s_walk_full |=> ind_overrun)
        else $error("indirect chain went past eight levels");
    AST_IND_COUNT: assert property (@(posedge mclk) disable iff (!rst_b)
        ind_lvl <= 4'(IND_MAX))
        else $error("indirect level counter overran");
    AST_IND_START: assert property (@(posedge mclk) disable iff (!rst_b)
        (ind_state == prs_pkg::PRS_IND_IDLE && ind_start) |=> (ind_busy && ind_lvl == 4'h1))
        else $error("indirect walk did not start at level one");
    AST_FP_ODD: assert property (@(posedge mclk) disable iff (!rst_b)
        (rd.op == prs_pkg::PRS_OP_FP_L && rd.sel[0]) |=> rd_bad_sel)
        else $error("odd floating register number accepted");
    AST_FP_SHORT_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
        (wr.en && wr.op == prs_pkg::PRS_OP_FP_S && fp_ok)
        |=> fp[$past(fp_idx)][31:0] == $past(fp[fp_idx][31:0]))
        else $error("short floating write touched lower half");
    AST_HALF_EXT: assert property (@(posedge mclk) disable iff (!rst_b)
        (wr.en && wr.op == prs_pkg::PRS_OP_GR_H)
        |=> gr[$past(bank_sel)][$past(wr.sel)] == $past(half_ext)
            && gr[$past(bank_sel)][$past(wr.sel)][31] == $past(wr.data[15]))
        else $error("half word load not sign extended");
    // double word write seen by a read of the same pair held one more cycle
    sequence s_dbl_wr;
        wr.en && wr.op == prs_pkg::PRS_OP_GR_D && rd.op == prs_pkg::PRS_OP_GR_D
            && rd.sel[3:1] == wr.sel[3:1];
    endsequence

    AST_DBL_PAIR: assert property (@(posedge mclk) disable iff (!rst_b)
        s_dbl_wr ##1 ($stable(rd) && $stable(bank_sel)) |=> rd_data == $past(wr.data, 2))
        else $error("double word pair mismatch");
    AST_GR_NEG: assert property (@(posedge mclk) disable iff (!rst_b)
        (rd.op == prs_pkg::PRS_OP_GR_W)
        |=> rd_neg == $past(gr[bank_sel][rd.sel][`PRS_SIGN_BIT]))
        else $error("fixed point sign flag wrong");

    sequence s_fp_refused;
        wr.en && !fp_ok
            && (wr.op == prs_pkg::PRS_OP_FP_S || wr.op == prs_pkg::PRS_OP_FP_L);
    endsequence

    AST_FP_REFUSE: assert property (@(posedge mclk) disable iff (!rst_b)
        s_fp_refused |=> fp[$past(fp_idx)] === $past(fp[fp_idx]))
        else $error("floating write to a refused number changed a register");
    AST_FP_EVEN: assert property (@(posedge mclk) disable iff (!rst_b)
        ((rd.op == prs_pkg::PRS_OP_FP_S || rd.op == prs_pkg::PRS_OP_FP_L) && rd_fp_ok)
        |=> !rd_bad_sel)
        else $error("even floating register number refused");
    AST_FP_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
        ((rd.op == prs_pkg::PRS_OP_FP_S || rd.op == prs_pkg::PRS_OP_FP_L) && rd.sel[3])
        |=> rd_bad_sel)
        else $error("floating register number above six accepted");

    // conversion moves the sign between the low nibble and the low zone
    sequence s_pack_wr;
        wr.en && wr.op == prs_pkg::PRS_OP_WK_CNV && wr.cnv == prs_pkg::PRS_CNV_PACK;
    endsequence

    sequence s_unpack_wr;
        wr.en && wr.op == prs_pkg::PRS_OP_WK_CNV && wr.cnv == prs_pkg::PRS_CNV_UNPACK;
    endsequence

    AST_WK_PACK: assert property (@(posedge mclk) disable iff (!rst_b)
        s_pack_wr |=> wk[$past(wk_idx)][3:0] == $past(wk[wk_idx][7:4])
            && wk[$past(wk_idx)][7:4] == $past(wk[wk_idx][3:0]))
        else $error("pack did not move the sign to the low nibble");
    AST_WK_UNPACK: assert property (@(posedge mclk) disable iff (!rst_b)
        s_unpack_wr |=> wk[$past(wk_idx)][7:4] == $past(wk[wk_idx][3:0])
            && wk[$past(wk_idx)][3:0] == $past(wk[wk_idx][7:4]))
        else $error("unpack did not move the sign to the low zone");

    sequence s_walk_end;
        ind_busy && !ind_more;
    endsequence

    AST_IND_END: assert property (@(posedge mclk) disable iff (!rst_b)
        s_walk_end |=> !ind_busy && !ind_overrun)
        else $error("indirect walk did not end when the chain stopped");
endmodule

/* File: tb/processor_register_stack_tb_top.sv */
// self-checking bench for the processor register stack
`timescale 1ns/1ns
module processor_register_stack_tb_top;
    logic             mclk = 1'b0;
    logic             rst_b = 1'b0;
    logic             bank_sel = 1'b0;
    prs_pkg::prs_wr_s wr;
    prs_pkg::prs_rd_s rd;
    logic [63:0]      rd_data;
    logic             rd_neg;
    logic             rd_bad_sel;
    logic [3:0]       idx1_sel = 4'h0;
    logic             idx1_en = 1'b0;
    logic [3:0]       idx2_sel = 4'h0;
    logic             idx2_en = 1'b0;
    logic [23:0]      disp = 24'h0;
    logic [23:0]      reloc = 24'h0;
    logic [23:0]      eff_addr;
    logic             ind_start = 1'b0;
    logic             ind_more = 1'b0;
    logic             ind_busy;
    logic             ind_overrun;
    int               n_mismatch = 0;
    int               tests_run = 0;

    always #20 mclk = ~mclk;

    prs_dpath_model u_dp (.mclk(mclk), .wr(wr), .rd(rd));

    prs_stack u_dut (
        .mclk(mclk), .rst_b(rst_b), .bank_sel(bank_sel), .wr(wr), .rd(rd),
        .rd_data(rd_data), .rd_neg(rd_neg), .rd_bad_sel(rd_bad_sel),
        .idx1_sel(idx1_sel), .idx1_en(idx1_en), .idx2_sel(idx2_sel),
        .idx2_en(idx2_en), .disp(disp), .reloc(reloc), .eff_addr(eff_addr),
        .ind_start(ind_start), .ind_more(ind_more), .ind_busy(ind_busy),
        .ind_overrun(ind_overrun)
    );

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // word-wide ops compare the low half only
    task automatic rchk(input prs_pkg::prs_op_e op, input logic [3:0] sel,
                        input logic [63:0] exp, input logic neg);
        u_dp.ask(op, sel);
        if (op == prs_pkg::PRS_OP_FP_L || op == prs_pkg::PRS_OP_GR_D)
            chk(rd_data, exp);
        else
            chk({32'h0, rd_data[31:0]}, exp);
        chk({63'h0, rd_neg}, {63'h0, neg});
        chk({63'h0, rd_bad_sel}, 64'h0);
    endtask

    task automatic t_gr;
        u_dp.put(prs_pkg::PRS_OP_GR_W, 4'h5, 64'h1234_5678, prs_pkg::PRS_CNV_NONE);
        @(posedge mclk) bank_sel <= 1'b1;
        u_dp.put(prs_pkg::PRS_OP_GR_W, 4'h5, 64'h8765_4321, prs_pkg::PRS_CNV_NONE);
        rchk(prs_pkg::PRS_OP_GR_W, 4'h5, 64'h8765_4321, 1'b1);
        @(posedge mclk) bank_sel <= 1'b0;
        rchk(prs_pkg::PRS_OP_GR_W, 4'h5, 64'h1234_5678, 1'b0);
    endtask

    task automatic t_half;
        u_dp.put(prs_pkg::PRS_OP_GR_H, 4'h3, 64'h8001, prs_pkg::PRS_CNV_NONE);
        rchk(prs_pkg::PRS_OP_GR_W, 4'h3, 64'hffff_8001, 1'b1);
        u_dp.put(prs_pkg::PRS_OP_GR_H, 4'h3, 64'h7fff, prs_pkg::PRS_CNV_NONE);
        rchk(prs_pkg::PRS_OP_GR_W, 4'h3, 64'h7fff, 1'b0);
    endtask

    task automatic t_dbl;
        u_dp.ask(prs_pkg::PRS_OP_GR_D, 4'h4);
        u_dp.put(prs_pkg::PRS_OP_GR_D, 4'h4, 64'h8000_0000_0000_0001,
                 prs_pkg::PRS_CNV_NONE);
        rchk(prs_pkg::PRS_OP_GR_D, 4'h5, 64'h8000_0000_0000_0001, 1'b1);
        rchk(prs_pkg::PRS_OP_GR_W, 4'h4, 64'h8000_0000, 1'b1);
        rchk(prs_pkg::PRS_OP_GR_W, 4'h5, 64'h1, 1'b0);
    endtask

    task automatic t_fp;
        u_dp.put(prs_pkg::PRS_OP_GR_W, 4'h2, 64'h5, prs_pkg::PRS_CNV_NONE);
        for (int i = 0; i < 8; i += 2)
            u_dp.put(prs_pkg::PRS_OP_FP_L, 4'(i), 64'h4110_0000_0000_0a00 + 64'(i),
                     prs_pkg::PRS_CNV_NONE);
        u_dp.put(prs_pkg::PRS_OP_FP_S, 4'h2, 64'hc220_0000_ffff_ffff,
                 prs_pkg::PRS_CNV_NONE);
        u_dp.put(prs_pkg::PRS_OP_FP_L, 4'h5, 64'h0, prs_pkg::PRS_CNV_NONE);
        rchk(prs_pkg::PRS_OP_FP_L, 4'h2, 64'hc220_0000_0000_0a02, 1'b1);
        rchk(prs_pkg::PRS_OP_FP_L, 4'h4, 64'h4110_0000_0000_0a04, 1'b0);
        rchk(prs_pkg::PRS_OP_GR_W, 4'h2, 64'h5, 1'b0);
        u_dp.ask(prs_pkg::PRS_OP_FP_L, 4'h3);
        chk({63'h0, rd_bad_sel}, 64'h1);
        u_dp.ask(prs_pkg::PRS_OP_FP_S, 4'h8);
        chk({63'h0, rd_bad_sel}, 64'h1);
    endtask

    task automatic t_dec;
        for (int i = 0; i < 8; i++)
            u_dp.put(prs_pkg::PRS_OP_WK, 4'(i), 64'(i) + 64'h11, prs_pkg::PRS_CNV_NONE);
        for (int i = 0; i < 8; i++)
            rchk(prs_pkg::PRS_OP_WK, 4'(i), 64'(i) + 64'h11, 1'b0);
        u_dp.put(prs_pkg::PRS_OP_WK, 4'h1, 64'hf1f2_f3d4, prs_pkg::PRS_CNV_NONE);
        u_dp.put(prs_pkg::PRS_OP_WK_CNV, 4'h1, 64'h0, prs_pkg::PRS_CNV_PACK);
        rchk(prs_pkg::PRS_OP_WK, 4'h1, 64'h0001_234d, 1'b1);
        u_dp.put(prs_pkg::PRS_OP_WK_CNV, 4'h1, 64'h0, prs_pkg::PRS_CNV_UNPACK);
        u_dp.ask(prs_pkg::PRS_OP_WK, 4'h1);
        chk({32'h0, rd_data[31:0]}, 64'h0102_03d4);
    endtask

    task automatic t_addr;
        u_dp.put(prs_pkg::PRS_OP_GR_W, 4'h1, 64'h100, prs_pkg::PRS_CNV_NONE);
        u_dp.put(prs_pkg::PRS_OP_GR_W, 4'h2, 64'h20, prs_pkg::PRS_CNV_NONE);
        @(posedge mclk);
        {idx1_sel, idx1_en, idx2_sel, idx2_en} <= {4'h1, 1'b1, 4'h2, 1'b1};
        {disp, reloc} <= {24'h4, 24'h1000};
        @(posedge mclk) #1;
        chk({40'h0, eff_addr}, 64'h1124);
        @(posedge mclk) idx1_sel <= 4'h0;
        @(posedge mclk) #1;
        chk({40'h0, eff_addr}, 64'h1024);
    endtask

    task automatic t_ind;
        int k;
        int n;
        n = 0;
        @(posedge mclk) {ind_start, ind_more} <= 2'b11;
        @(posedge mclk) ind_start <= 1'b0;
        for (k = 0; k < 20; k++) begin
            #1;
            if (ind_overrun === 1'b1) break;
            if (ind_busy === 1'b1) n++;
            @(posedge mclk);
        end
        chk(64'(k < 20), 64'h1);
        chk(64'(n), 64'h8);
        @(posedge mclk) ind_more <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk({63'h0, ind_busy}, 64'h0);
        @(posedge mclk) {ind_start, ind_more} <= 2'b11;
        @(posedge mclk) ind_start <= 1'b0;
        @(posedge mclk) ind_more <= 1'b0;
        #1;
        chk({63'h0, ind_busy}, 64'h1);
        @(posedge mclk) #1;
        chk({62'h0, ind_busy, ind_overrun}, 64'h0);
    endtask

    // mid-run reset: rd_data, eff_addr and ind_busy clear, then eff_addr follows its inputs again
    task automatic t_rst;
        u_dp.ask(prs_pkg::PRS_OP_GR_W, 4'h1);
        chk(rd_data, 64'h100);
        @(posedge mclk) rst_b <= 1'b0;
        #1;
        chk(rd_data, 64'h0);
        chk({39'h0, eff_addr, ind_busy}, 64'h0);
        @(posedge mclk) begin
            rst_b   <= 1'b1;
            idx2_en <= 1'b0;
        end
        @(posedge mclk) #1;
        chk({40'h0, eff_addr}, 64'h1004);
    endtask

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        t_gr();
        t_half();
        t_dbl();
        t_fp();
        t_dec();
        t_addr();
        t_ind();
        t_rst();
        test_done();
    end
endmodule

/* File: tb/prs_dpath_model.sv */
// partner model: microprogram datapath issuing register requests
`timescale 1ns/1ns
module prs_dpath_model (
    input  wire logic        mclk,
    output prs_pkg::prs_wr_s wr,
    output prs_pkg::prs_rd_s rd
);
    initial begin
        wr = '0;
        rd = '0;
    end

    // one write, strobe dropped at the edge that takes it
    task automatic put(input prs_pkg::prs_op_e op, input logic [3:0] sel,
                       input logic [63:0] d, input prs_pkg::prs_cnv_e c);
        @(posedge mclk);
        wr <= '{1'b1, op, sel, d, c};
        @(posedge mclk);
        wr.en <= 1'b0;
    endtask

    // read select held, answer settled one edge later
    task automatic ask(input prs_pkg::prs_op_e op, input logic [3:0] sel);
        @(posedge mclk);
        rd <= '{op, sel};
        @(posedge mclk);
        #1;
    endtask
endmodule
